// [verilog/dca_cfg.svh]
// Register indices, field positions and codes of the DMA addressing block
`ifndef DCA_CFG_SVH
`define DCA_CFG_SVH
// Register indices; byte address is four times the index
`define DCA_IDX_CTL0 12'hfb0
`define DCA_IDX_IO0 12'hfb1
`define DCA_IDX_HI0 12'hfb2
`define DCA_IDX_ST0 12'hfb3
`define DCA_IDX_END0 12'hfb4
`define DCA_IDX_CTL1 12'hfb8
`define DCA_IDX_IO1 12'hfb9
`define DCA_IDX_HI1 12'hfba
`define DCA_IDX_ST1 12'hfbb
`define DCA_IDX_END1 12'hfbc
`define DCA_IDX_CONV 12'hfbd
`define DCA_IDX_STAT 12'hfbe
// Decoded register selects
`define DCA_SEL_CTL 3'h0
`define DCA_SEL_IO 3'h1
`define DCA_SEL_HI 3'h2
`define DCA_SEL_ST 3'h3
`define DCA_SEL_END 3'h4
`define DCA_SEL_CONV 3'h5
`define DCA_SEL_STAT 3'h6
`define DCA_SEL_NONE 3'h7
// Control register fields
`define DCA_CTL_EN 7
`define DCA_CTL_DIR 6
`define DCA_CTL_WORD_SELECT 3
`define DCA_CTL_MASK 7'h4f
`define DCA_CTL_RST 7'h00
// Status register: busy bits start here, done bits at zero
`define DCA_STAT_BUSY 2
// Fixed upper nibble of the peripheral page
`define DCA_PAGE 4'hf
// Address steps for byte and word moves
`define DCA_STEP_BYTE 12'h001
`define DCA_STEP_WORD 12'h002
`endif

// [verilog/dca_pkg.sv]
// Types and register decode of the DMA addressing block
package dca_pkg;
`include "dca_cfg.svh"

   // Channel state, one-hot
   typedef enum logic [1:0] {
      CH_IDLE = 2'b01,
      CH_RUN = 2'b10
   } dca_ch_e;

   // Trigger source codes
   typedef enum logic [2:0] {
      TRIG_TMR0 = 3'h0,
      TRIG_TMR1 = 3'h1,
      TRIG_TMR2 = 3'h2,
      TRIG_TMR3 = 3'h3,
      TRIG_URX = 3'h4,
      TRIG_UTX = 3'h5,
      TRIG_I2C = 3'h6,
      TRIG_RSVD = 3'h7
   } dca_trig_e;

   // One move handed to the data path
   typedef struct packed {
      logic word_select;
      logic dir;
      logic chan;
      logic [11:0] periph_addr;
      logic [11:0] mem_addr;
   } dca_cmd_s;

   // Register index to {channel, select}
   function automatic logic [3:0] dca_dec(input logic [11:0] idx);
      logic [3:0] r;
      r = {1'b0, `DCA_SEL_NONE};
      case (idx)
         `DCA_IDX_CTL0: r = {1'b0, `DCA_SEL_CTL};
         `DCA_IDX_IO0: r = {1'b0, `DCA_SEL_IO};
         `DCA_IDX_HI0: r = {1'b0, `DCA_SEL_HI};
         `DCA_IDX_ST0: r = {1'b0, `DCA_SEL_ST};
         `DCA_IDX_END0: r = {1'b0, `DCA_SEL_END};
         `DCA_IDX_CTL1: r = {1'b1, `DCA_SEL_CTL};
         `DCA_IDX_IO1: r = {1'b1, `DCA_SEL_IO};
         `DCA_IDX_HI1: r = {1'b1, `DCA_SEL_HI};
         `DCA_IDX_ST1: r = {1'b1, `DCA_SEL_ST};
         `DCA_IDX_END1: r = {1'b1, `DCA_SEL_END};
         `DCA_IDX_CONV: r = {1'b0, `DCA_SEL_CONV};
         `DCA_IDX_STAT: r = {1'b0, `DCA_SEL_STAT};
         default: r = {1'b0, `DCA_SEL_NONE};
      endcase
      return r;
   endfunction : dca_dec
endpackage : dca_pkg

// [verilog/dca_stream_if.sv]
// Valid/ready stream carrier between the channel logic and the FIFO
`timescale 1ns/1ns
interface dca_stream_if #(parameter int W = 8) ();
   logic valid; // Word offered
   logic ready; // Word can be taken
   logic [W-1:0] data; // Payload
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : dca_stream_if

// [verilog/dca_fifo.sv]
// Shift-register FIFO with registered head word and valid
`timescale 1ns/1ns
module dca_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 4
) (
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic ce_i,
   // Fill side
   dca_stream_if.snk wr_if,
   // Drain side
   dca_stream_if.src rd_if
);
   import dca_pkg::*;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL = CW'(DEPTH);
   localparam logic [CW-1:0] ONE = CW'(1);

   logic [W-1:0] mem_q [DEPTH]; // Slot 0 is the head, a flop
   logic [CW-1:0] cnt_q; // Words held
   logic [CW-1:0] cnt_d;
   logic [CW-1:0] wpos_w; // Slot the new word lands in
   logic valid_q; // Registered not-empty
   logic push_w;
   logic pop_w;

   // Full refuses input; the source must hold its word
   assign wr_if.ready = (cnt_q != FULL);
   assign rd_if.valid = valid_q;
   assign rd_if.data = mem_q[0];
   assign push_w = wr_if.valid & wr_if.ready & ce_i;
   assign pop_w = valid_q & rd_if.ready & ce_i;

   // Next fill level and write slot
   always_comb begin
      cnt_d = cnt_q;
      if (push_w && !pop_w) begin
         cnt_d = cnt_q + ONE;
      end else if (pop_w && !push_w) begin
         cnt_d = cnt_q - ONE;
      end
      wpos_w = pop_w ? cnt_q - ONE : cnt_q;
   end

   // Level and valid flag
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_q <= '0;
         valid_q <= 1'b0;
      end else if (ce_i) begin
         cnt_q <= cnt_d;
         valid_q <= (cnt_d != '0);
      end
   end

   // Storage; data needs no reset, valid guards it
   always_ff @(posedge clk_i) begin
      if (ce_i) begin
         for (int i = 0; i < DEPTH - 1; i++) begin
            if (pop_w) begin
               mem_q[i] <= mem_q[i + 1];
            end
         end
         for (int i = 0; i < DEPTH; i++) begin
            if (push_w && wpos_w == CW'(i)) begin
               mem_q[i] <= wr_if.data;
            end
         end
      end
   end
endmodule : dca_fifo

// [verilog/dca_top.sv]
// Two-channel DMA addressing and trigger logic with APB registers
//
// Overview of operation
// RULE_01 - word_select picks byte or word per request
// RULE_02 - Software uses even peripheral address for words
// RULE_03 - Trigger codes 0-3 timers, 7 reserved
// RULE_04 - Codes 4-6: UART receive, transmit, I2C events
// RULE_05 - Trigger ignores interrupt controller enable
// RULE_06 - Peripheral address is page F plus byte
// RULE_07 - Start and end high nibbles share register
// RULE_08 - Start low byte reads current address
// RULE_09 - Separate end address low byte register
// RULE_10 - Converter target register, bit zero reserved
// RULE_11 - Address registers unreset, software programs first
// RULE_12 - Each request moves, advances, stops at end
//
// Our own choice: the APB slave port.
`timescale 1ns/1ns
module dca_top #(
   parameter int AW = 16,
   parameter int FIFO_DEPTH = 4
) (
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic ce_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [AW-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Trigger events from peripherals, already gated by their own enables
   input wire logic [3:0] timer_trig_i,
   input wire logic [1:0] uart_rx_avail_i,
   input wire logic [1:0] uart_tx_empty_i,
   input wire logic i2c_rx_evt_i,
   input wire logic i2c_tx_evt_i,
   // Move commands to the data path
   output logic xfer_valid_o,
   input wire logic xfer_ready_i,
   output logic xfer_word_o,
   output logic xfer_dir_o,
   output logic xfer_chan_o,
   output logic [11:0] xfer_periph_addr_o,
   output logic [11:0] xfer_mem_addr_o,
   // Status and converter target
   output logic [1:0] busy_o,
   output logic [7:0] conv_target_addr_o
);
   import dca_pkg::*;
   localparam int CW = $bits(dca_cmd_s);

   // Channel registers
   logic [6:0] ctl_q [2]; // Direction, word_select, trigger_source_select
   logic [7:0] io_q [2]; // Peripheral address low byte
   logic [7:0] hi_q [2]; // End nibble [7:4], start nibble [3:0]
   logic [7:0] st_q [2]; // Start, then current, address low byte
   logic [7:0] end_q [2]; // End address low byte
   logic [7:0] conv_q; // Converter target, bit 0 held zero
   dca_ch_e state_q [2]; // Idle or running
   logic [1:0] done_q; // Block finished, sticky
   logic [1:0] pend_q; // Request waiting for the FIFO
   logic [1:0] prev_q; // Last trigger level, edge detect
   // APB answer flops
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;

   // Decode and datapath wires
   logic [3:0] dec_w; // {channel, select}
   logic wr_w; // Write completes this edge
   logic [31:0] rd_w; // Read mux
   logic [11:0] cur_w [2]; // Current memory address
   logic [11:0] end_w [2]; // Last memory address
   logic [11:0] nxt_w [2]; // Address after this move
   logic [1:0] last_w; // This move reaches the end
   logic [1:0] src_w; // Selected trigger level
   logic [1:0] run_w; // Channel running
   logic [1:0] acc_w; // Move taken by the FIFO
   logic sel_w; // Channel offered to the FIFO
   dca_cmd_s cmd_w; // Command offered
   dca_cmd_s head_w; // FIFO head

   dca_stream_if #(.W(CW)) push_if ();
   dca_stream_if #(.W(CW)) pop_if ();

   assign dec_w = dca_dec(paddr_i[13:2]);
   // Writes land only at the completing access edge
   assign wr_w = ce_i & psel_i & penable_i & pwrite_i & pready_q;

   // Per-channel address arithmetic
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         run_w[c] = (state_q[c] == CH_RUN);
         cur_w[c] = {hi_q[c][3:0], st_q[c]}; // RULE_07 RULE_08
         end_w[c] = {hi_q[c][7:4], end_q[c]}; // RULE_07 RULE_09
         // Byte moves step one, word moves step two
         nxt_w[c] = cur_w[c] + (ctl_q[c][`DCA_CTL_WORD_SELECT] ?
            `DCA_STEP_WORD : `DCA_STEP_BYTE); // RULE_01
         // A word ends once its second byte reaches the end
         if (ctl_q[c][`DCA_CTL_WORD_SELECT]) begin
            last_w[c] = (12'(cur_w[c] + `DCA_STEP_BYTE) >= end_w[c]);
         end else begin
            last_w[c] = (cur_w[c] >= end_w[c]); // RULE_12
         end
      end
   end

   // Trigger source mux; only the source's own level counts, so an
   // interrupt masked in the interrupt controller still triggers
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         case (ctl_q[c][2:0])
            TRIG_TMR0, TRIG_TMR1, TRIG_TMR2, TRIG_TMR3: begin
               src_w[c] = timer_trig_i[ctl_q[c][1:0]]; // RULE_03 RULE_05
            end
            TRIG_URX: begin
               src_w[c] = uart_rx_avail_i[c]; // RULE_04
            end
            TRIG_UTX: begin
               src_w[c] = uart_tx_empty_i[c]; // RULE_04
            end
            TRIG_I2C: begin
               src_w[c] = (c == 0) ? i2c_rx_evt_i : i2c_tx_evt_i; // RULE_04
            end
            default: begin
               src_w[c] = 1'b0; // RULE_03
            end
         endcase
      end
   end

   // Arbitration; channel 0 wins, the loser waits in pend_q
   always_comb begin
      sel_w = ~(pend_q[0] & run_w[0]);
      cmd_w.word_select = ctl_q[sel_w][`DCA_CTL_WORD_SELECT];
      cmd_w.dir = ctl_q[sel_w][`DCA_CTL_DIR];
      cmd_w.chan = sel_w;
      // Odd address in word mode is passed on unchecked
      cmd_w.periph_addr = {`DCA_PAGE, io_q[sel_w]}; // RULE_06 RULE_02
      cmd_w.mem_addr = cur_w[sel_w];
      push_if.valid = pend_q[sel_w] & run_w[sel_w];
      push_if.data = cmd_w;
      for (int c = 0; c < 2; c++) begin
         acc_w[c] = push_if.valid & push_if.ready & ce_i & (sel_w == c);
      end
   end

   // Command buffer; a full FIFO stalls the channels
   dca_fifo #(.W(CW), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .ce_i(ce_i),
      .wr_if(push_if),
      .rd_if(pop_if)
   );
   assign pop_if.ready = xfer_ready_i;
   assign head_w = pop_if.data;

   // Address registers: no reset, contents undefined until written
   always_ff @(posedge clk_i) begin // RULE_11
      if (ce_i) begin
         for (int c = 0; c < 2; c++) begin
            if (wr_w && dec_w == {c[0], `DCA_SEL_IO}) begin
               io_q[c] <= pwdata_i[7:0];
            end
            if (wr_w && dec_w == {c[0], `DCA_SEL_END}) begin
               end_q[c] <= pwdata_i[7:0]; // RULE_09
            end
            // Software write beats the hardware advance
            if (wr_w && dec_w == {c[0], `DCA_SEL_HI}) begin
               hi_q[c] <= pwdata_i[7:0]; // RULE_07
            end else if (acc_w[c]) begin
               hi_q[c][3:0] <= nxt_w[c][11:8]; // RULE_12
            end
            if (wr_w && dec_w == {c[0], `DCA_SEL_ST}) begin
               st_q[c] <= pwdata_i[7:0];
            end else if (acc_w[c]) begin
               st_q[c] <= nxt_w[c][7:0]; // RULE_08 RULE_12
            end
         end
         if (wr_w && dec_w == {1'b0, `DCA_SEL_CONV}) begin
            conv_q <= {pwdata_i[7:1], 1'b0}; // RULE_10
         end
      end
   end

   // Control registers
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ctl_q[0] <= `DCA_CTL_RST;
         ctl_q[1] <= `DCA_CTL_RST;
      end else if (ce_i) begin
         for (int c = 0; c < 2; c++) begin
            if (wr_w && dec_w == {c[0], `DCA_SEL_CTL}) begin
               ctl_q[c] <= pwdata_i[6:0] & `DCA_CTL_MASK; // RULE_01 RULE_03
            end
         end
      end
   end

   // Channel state: enabled by software, stopped at the end address
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_q[0] <= CH_IDLE;
         state_q[1] <= CH_IDLE;
      end else if (ce_i) begin
         for (int c = 0; c < 2; c++) begin
            case (state_q[c])
               CH_IDLE: begin
                  if (wr_w && dec_w == {c[0], `DCA_SEL_CTL} &&
                      pwdata_i[`DCA_CTL_EN]) begin
                     state_q[c] <= CH_RUN;
                  end
               end
               CH_RUN: begin
                  if (wr_w && dec_w == {c[0], `DCA_SEL_CTL} &&
                      !pwdata_i[`DCA_CTL_EN]) begin
                     state_q[c] <= CH_IDLE;
                  end else if (acc_w[c] && last_w[c]) begin
                     state_q[c] <= CH_IDLE; // RULE_12
                  end
               end
               default: begin
                  state_q[c] <= CH_IDLE;
               end
            endcase
         end
      end
   end

   // Trigger edges and pending requests; a new edge beats the clear
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         prev_q <= 2'h0;
         pend_q <= 2'h0;
      end else if (ce_i) begin
         prev_q <= src_w;
         for (int c = 0; c < 2; c++) begin
            if (run_w[c] && src_w[c] && !prev_q[c]) begin
               pend_q[c] <= 1'b1; // RULE_03 RULE_04
            end else if (acc_w[c] || !run_w[c]) begin
               pend_q[c] <= 1'b0; // RULE_12
            end
         end
      end
   end

   // Done flags, write one to clear; completion beats the clear
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         done_q <= 2'h0;
      end else if (ce_i) begin
         for (int c = 0; c < 2; c++) begin
            if (acc_w[c] && last_w[c]) begin
               done_q[c] <= 1'b1;
            end else if (wr_w && dec_w == {1'b0, `DCA_SEL_STAT} &&
                         pwdata_i[c]) begin
               done_q[c] <= 1'b0;
            end
         end
      end
   end

   // Read mux; unused bits read zero
   always_comb begin
      rd_w = 32'h0;
      case (dec_w[2:0])
         `DCA_SEL_CTL: rd_w[7:0] = {run_w[dec_w[3]], ctl_q[dec_w[3]]};
         `DCA_SEL_IO: rd_w[7:0] = io_q[dec_w[3]];
         `DCA_SEL_HI: rd_w[7:0] = hi_q[dec_w[3]];
         `DCA_SEL_ST: rd_w[7:0] = st_q[dec_w[3]]; // RULE_08
         `DCA_SEL_END: rd_w[7:0] = end_q[dec_w[3]];
         `DCA_SEL_CONV: rd_w[7:0] = conv_q; // RULE_10
         `DCA_SEL_STAT: rd_w[3:0] = {run_w, done_q};
         default: rd_w = 32'h0;
      endcase
   end

   // APB answer: decode in setup, ready in access, no wait states
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         prdata_q <= 32'h0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else if (ce_i) begin
         pready_q <= psel_i & ~penable_i;
         pslverr_q <= psel_i & ~penable_i &
            (dec_w[2:0] == `DCA_SEL_NONE);
         if (psel_i && !penable_i) begin
            prdata_q <= pwrite_i ? 32'h0 : rd_w;
         end
      end
   end

   // Outputs straight from flops
   assign prdata_o = prdata_q;
   assign pready_o = pready_q;
   assign pslverr_o = pslverr_q;
   assign xfer_valid_o = pop_if.valid;
   assign xfer_word_o = head_w.word_select;
   assign xfer_dir_o = head_w.dir;
   assign xfer_chan_o = head_w.chan;
   assign xfer_periph_addr_o = head_w.periph_addr;
   assign xfer_mem_addr_o = head_w.mem_addr;
   assign busy_o = {state_q[1][1], state_q[0][1]};
   assign conv_target_addr_o = conv_q;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!arst_n_i);

   chk_apb_ready: assert property ( // bus
      ce_i && psel_i && !penable_i |=> pready_o)
      else $error("ready missing after setup");
   chk_word_step: assert property ( // RULE_01
      ce_i && acc_w[0] && !wr_w |=> cur_w[0] == 12'($past(cur_w[0]) +
      ($past(ctl_q[0][`DCA_CTL_WORD_SELECT]) ? 12'h002 : 12'h001)))
      else $error("address step wrong");
   chk_timer_trig: assert property ( // RULE_03
      ce_i && run_w[0] && ctl_q[0][2:0] == 3'h1 && timer_trig_i[1] &&
      !prev_q[0] |=> pend_q[0])
      else $error("timer trigger lost");
   chk_reserved_src: assert property ( // RULE_03
      ctl_q[0][2:0] == 3'h7 |-> !src_w[0])
      else $error("reserved code triggered");
   chk_uart_rx_src: assert property ( // RULE_04
      ctl_q[1][2:0] == 3'h4 |-> src_w[1] == uart_rx_avail_i[1])
      else $error("uart receive source wrong");
   chk_i2c_src: assert property ( // RULE_04
      ctl_q[1][2:0] == 3'h6 |-> src_w[1] == i2c_tx_evt_i)
      else $error("i2c source wrong");
   chk_periph_page: assert property ( // RULE_06
      push_if.valid |-> cmd_w.periph_addr[11:8] == 4'hf)
      else $error("peripheral page wrong");
   chk_stop_at_end: assert property ( // RULE_12
      ce_i && acc_w[0] && last_w[0] |=> !busy_o[0] && done_q[0])
      else $error("channel ran past end");
   chk_conv_lsb: assert property ( // RULE_10
      wr_w && dec_w == {1'b0, `DCA_SEL_CONV} |=> !conv_target_addr_o[0])
      else $error("reserved bit set");
endmodule : dca_top

// [tb/dca_peer_model.sv]
// Peripheral event sources and data-path consumer beside the block
`timescale 1ns/1ns
module dca_peer_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Consumer stall from the bench
   input wire logic stall_i,
   // Events: timers 3:0, rx 5:4, tx 7:6, i2c rx 8, i2c tx 9
   output logic [9:0] evt_o,
   // Move commands from the block
   input wire logic xfer_valid_i,
   output logic xfer_ready_o,
   input wire logic [26:0] cmd_i
);
   logic [26:0] got[$]; // Commands taken, oldest first

   // Levels come straight from the sources, no interrupt controller
   initial evt_o = 10'h000;

   // Takes at once unless stalled, so slow answers can be forced
   assign xfer_ready_o = ~stall_i;

   // Log each command on the edge that takes it
   always @(posedge clk_i) begin
      if (arst_n_i && xfer_valid_i && xfer_ready_o) begin
         got.push_back(cmd_i);
      end
   end

   // One request: level held two cycles, so only its rise may count
   task automatic fire(input int i);
      @(posedge clk_i);
      evt_o[i] <= 1'b1;
      repeat (2) @(posedge clk_i);
      evt_o[i] <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask : fire
endmodule : dca_peer_model

// [tb/tb.sv]
// Self-checking bench of the DMA addressing block
`timescale 1ns/1ns
`include "dca_cfg.svh"
module tb;
   import dca_pkg::*;
   logic clk_i = 1'b0; // 250 MHz clock
   logic arst_n_i = 1'b0; // Reset, active low
   logic psel = 1'b0; // APB request
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [15:0] paddr = 16'h0000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready, pslverr, xvalid, xready, xword, xdir, xchan;
   logic stall = 1'b0; // Consumer stall
   logic ce = 1'b1; // Clock enable of the block
   logic [11:0] xpa, xma;
   logic [1:0] busy;
   logic [7:0] conv;
   logic [9:0] evt;
   logic [26:0] cmd; // Packed command seen by the consumer
   logic [31:0] rd; // Last read data
   logic err; // Last error flag
   int mismatches = 0;
   int total_checks = 0;

   assign cmd = {xdir, xchan, xword, xpa, xma};

   // Clock
   always #2 clk_i = ~clk_i;

   dca_top i_dut (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr),
      .timer_trig_i(evt[3:0]), .uart_rx_avail_i(evt[5:4]),
      .uart_tx_empty_i(evt[7:6]), .i2c_rx_evt_i(evt[8]),
      .i2c_tx_evt_i(evt[9]), .xfer_valid_o(xvalid),
      .xfer_ready_i(xready), .xfer_word_o(xword), .xfer_dir_o(xdir),
      .xfer_chan_o(xchan), .xfer_periph_addr_o(xpa),
      .xfer_mem_addr_o(xma), .busy_o(busy), .conv_target_addr_o(conv));

   dca_peer_model i_peer (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .stall_i(stall), .evt_o(evt),
      .xfer_valid_i(xvalid), .xfer_ready_o(xready), .cmd_i(cmd));

   // Compare and count
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   // One APB transfer; waits for pready, no fixed latency assumed
   task automatic apb(input logic wr, input logic [11:0] idx,
                      input logic [7:0] wd);
      int n;
      n = 0;
      @(posedge clk_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge clk_i);
      penable <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      check({31'h0, pready}, 32'h1);
   endtask : apb

   task automatic wr(input logic [11:0] idx, input logic [7:0] d);
      apb(1'b1, idx, d);
   endtask : wr

   // Read and compare data and error flag
   task automatic rdc(input logic [11:0] idx, input logic [7:0] exp,
                      input logic e);
      apb(1'b0, idx, 8'h00);
      check(rd, {24'h000000, exp});
      check({31'h0, err}, {31'h0, e});
   endtask : rdc

   // Expect one command, bounded wait
   task automatic take(input logic [26:0] exp);
      int n;
      n = 0;
      while (i_peer.got.size() == 0 && n < 100) begin
         @(posedge clk_i);
         n++;
      end
      if (i_peer.got.size() == 0) check(32'h0, {5'h1f, exp});
      else check({5'h0, i_peer.got.pop_front()}, {5'h0, exp});
   endtask : take

   // Expect nothing to reach the consumer
   task automatic none();
      repeat (8) @(posedge clk_i);
      check(i_peer.got.size(), 32'h0);
   endtask : none

   function automatic logic [7:0] ctl(input logic en, input logic dir,
                                      input logic w, input logic [2:0] c);
      return {en, dir, 2'b00, w, c};
   endfunction : ctl

   // Verdict, reached from the sequence or the watchdog
   task automatic end_of_test();
      $display("checks=%0d mismatches=%0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_of_test

   // Watchdog, far beyond the thousand or fewer cycles needed
   initial begin
      repeat (20000) @(posedge clk_i);
      mismatches++;
      end_of_test();
   end

   // Main sequence
   initial begin
      logic [11:0] b; // Channel register base offset
      int r; // Matching event
      repeat (3) @(posedge clk_i);
      arst_n_i <= 1'b1;
      rdc(`DCA_IDX_CTL0, 8'h00, 1'b0);
      rdc(`DCA_IDX_STAT, 8'h00, 1'b0);
      wr(12'hfb5, 8'h55);
      rdc(12'hfb5, 8'h00, 1'b1);
      // Address registers read back as written; converter target drops bit 0
      wr(`DCA_IDX_IO0, 8'ha5);
      wr(`DCA_IDX_HI0, 8'h3c);
      wr(`DCA_IDX_END0, 8'h7e);
      wr(`DCA_IDX_CONV, 8'h5b);
      rdc(`DCA_IDX_IO0, 8'ha5, 1'b0);
      rdc(`DCA_IDX_HI0, 8'h3c, 1'b0);
      rdc(`DCA_IDX_END0, 8'h7e, 1'b0);
      check({24'h0, conv}, 32'h5a);
      // Trigger codes 0-6 on both channels, wrong source first
      for (int ch = 0; ch < 2; ch++) begin
         b = (ch == 0) ? 12'h000 : 12'h008;
         for (int c = 0; c < 7; c++) begin
            r = (c < 4) ? c : (c == 4) ? 4 + ch : (c == 5) ? 6 + ch : 8 + ch;
            wr(`DCA_IDX_IO0 + b, 8'(8'h40 + 2 * c));
            wr(`DCA_IDX_HI0 + b, 8'hf1);
            wr(`DCA_IDX_ST0 + b, 8'(8'h10 * c));
            wr(`DCA_IDX_END0 + b, 8'hff);
            wr(`DCA_IDX_CTL0 + b, ctl(1'b1, ch[0], 1'b0, c[2:0]));
            // Busy is launched at the completing edge; look one later
            @(posedge clk_i);
            check({30'h0, busy}, 32'(ch + 1));
            i_peer.fire((r + 1) % 10);
            none();
            i_peer.fire(r);
            take({ch[0], ch[0], 1'b0, 4'hf, 8'(8'h40 + 2 * c), 4'h1,
                  8'(8'h10 * c)});
            wr(`DCA_IDX_CTL0 + b, 8'h00);
         end
      end
      // Reserved code never starts a move
      wr(`DCA_IDX_CTL0, ctl(1'b1, 1'b0, 1'b0, 3'h7));
      for (int i = 0; i < 10; i++) i_peer.fire(i);
      none();
      wr(`DCA_IDX_CTL0, 8'h00);
      // Word moves: step of two, stop at end
      wr(`DCA_IDX_IO0, 8'h20);
      wr(`DCA_IDX_HI0, 8'h22);
      wr(`DCA_IDX_ST0, 8'h10);
      wr(`DCA_IDX_END0, 8'h13);
      wr(`DCA_IDX_CTL0, ctl(1'b1, 1'b0, 1'b1, 3'h0));
      i_peer.fire(0);
      take({3'b001, 12'hf20, 12'h210});
      rdc(`DCA_IDX_ST0, 8'h12, 1'b0);
      i_peer.fire(0);
      take({3'b001, 12'hf20, 12'h212});
      check({30'h0, busy}, 32'h0);
      rdc(`DCA_IDX_STAT, 8'h01, 1'b0);
      rdc(`DCA_IDX_CTL0, 8'h08, 1'b0);
      i_peer.fire(0);
      none();
      wr(`DCA_IDX_STAT, 8'h01);
      rdc(`DCA_IDX_STAT, 8'h00, 1'b0);
      // Byte moves with the consumer stalled: fill, merge, drain
      wr(`DCA_IDX_IO1, 8'h33);
      wr(`DCA_IDX_HI1, 8'h11);
      wr(`DCA_IDX_ST1, 8'h00);
      wr(`DCA_IDX_END1, 8'h04);
      wr(`DCA_IDX_CTL1, ctl(1'b1, 1'b0, 1'b0, 3'h4));
      stall <= 1'b1;
      for (int i = 0; i < 6; i++) i_peer.fire(5);
      check({31'h0, xvalid}, 32'h1);
      check({5'h0, cmd}, {5'h0, 3'b010, 12'hf33, 12'h100});
      check({30'h0, busy}, 32'h2);
      stall <= 1'b0;
      for (int k = 0; k < 5; k++) begin
         take({3'b010, 12'hf33, 12'(12'h100 + k)});
      end
      none();
      rdc(`DCA_IDX_STAT, 8'h02, 1'b0);
      wr(`DCA_IDX_STAT, 8'h02);
      rdc(`DCA_IDX_STAT, 8'h00, 1'b0);
      // Enable low freezes the edge detector, so a pulse is lost
      wr(`DCA_IDX_CTL0, ctl(1'b1, 1'b0, 1'b0, 3'h0));
      ce <= 1'b0;
      i_peer.fire(0);
      ce <= 1'b1;
      none();
      i_peer.fire(0);
      take({3'b000, 12'hf20, 12'h214});
      end_of_test();
   end
endmodule : tb
